// [hw/turn_tally_pkg.sv]
// constants shared by the turn tally register group
package turn_tally_pkg;
    localparam logic [6:0] ANGLE_MAIN_ADDR = 7'h0e;
    localparam logic [6:0] PRIMARY_LIVE_ADDR = 7'h13;
    localparam logic [6:0] PRIMARY_SNAP_ADDR = 7'h19;
    localparam logic [6:0] SECONDARY_TALLY_ADDR = 7'h1a;
    localparam logic [6:0] SECONDARY_SNAP_ADDR = 7'h1b;
    localparam logic [6:0] UNLOCK_ADDR = 7'h1e;
    localparam logic [6:0] ECHO_ADDR = 7'h1f;
    localparam int ANY_FAULT_BIT = 15;
    localparam int SLEEP_RET_BIT = 14;
    localparam int WARN_BIT = 13;
    localparam int OVF_BIT = 12;
    localparam int CUSTOMER_BIT = 1;
    localparam int FACTORY_BIT = 0;
    localparam int WRITE_FLAG_BIT = 7;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [10:0] TALLY_MAX = 11'h3ff;
    localparam logic [10:0] TALLY_MIN = 11'h400;
    localparam logic [10:0] TALLY_RESET_VAL = 11'h000;
    localparam logic [15:0] WORD_RESET_VAL = 16'h0000;
    typedef enum logic [1:0] {LINK_IDLE, LINK_CMD, LINK_DATA} link_state_e;
endpackage

// [hw/turn_tally_regs.sv]
// turn tally status, snapshot, unlock and echo registers behind a serial link
`timescale 1ns/1ns
`default_nettype none
// Contract
// - reading the angle register snapshots both tallies and their flags together
// - secondary tally bit 15 is primary overflow OR primary warning
// - bit 14 sets on low-power exit without transport mode, clears on read
// - secondary warning follows supply, field and low-power accuracy faults
// - stuck-at-zero check at power-on and low-power exit, sticky until reset
// - overspeed also raises the secondary warning
// - warning reads 0 when clean, 1 when the count may be wrong
// - secondary overflow outside -1024..1023, held until tally reset
// - secondary tally is 11-bit signed quarter-turn count from power-on
// - secondary tally counts the redundant path chosen by the select field
// - writing the unlock register is a command, not stored data
// - unlock bit 1 shows customer space unlocked
// - unlock bit 0 shows factory space unlocked
// - 16-bit echo word reads back what was written
// - primary overflow outside -1024..1023, held until tally reset
// - primary tally is 11-bit signed quarter-turn count from main path
module turn_tally_regs #(
    parameter logic [15:0] CUSTOMER_KEY = 16'h5a01, // arbitrary value
    parameter logic [15:0] FACTORY_KEY = 16'ha502 // arbitrary value
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // serial link
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE_N,
    // angle and step sources
    input wire logic [15:0] ANGLE_MAIN,
    input wire logic PRI_STEP_UP,
    input wire logic PRI_STEP_DN,
    input wire logic [2:0] RED_STEP_UP,
    input wire logic [2:0] RED_STEP_DN,
    input wire logic [1:0] REDUNDANT_PATH_SELECT,
    // conditions
    input wire logic LOW_POWER,
    input wire logic TRANSPORT_EN,
    input wire logic SUPPLY_FAULT_A,
    input wire logic FIELD_FAULT_B,
    input wire logic SUPPLY_UNDERVOLT_FAULT,
    input wire logic LP_ACCURACY_THREAT,
    input wire logic OVERSPEED,
    input wire logic PRI_WARN_COND,
    input wire logic STUCK_ZERO_SEEN,
    input wire logic TALLY_RESET_CMD,
    // status out
    output logic STUCK_CHECK,
    output logic CUSTOMER_UNLOCKED,
    output logic FACTORY_UNLOCKED
);
    // link side: every input pin passes two flops; stage one feeds stage two only
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic sclk_prev_q;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_q <= 3'h2;
            sync2_q <= 3'h2;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= {SCLK, CS_N, MOSI};
            sync2_q <= sync1_q;
            sclk_prev_q <= sync2_q[2];
        end
    end
    logic sclk_rise;
    logic sclk_fall;
    logic cs_act;
    logic mosi_s;
    assign sclk_rise = sync2_q[2] & ~sclk_prev_q;
    assign sclk_fall = ~sync2_q[2] & sclk_prev_q;
    assign cs_act = ~sync2_q[1];
    assign mosi_s = sync2_q[0];

    turn_tally_pkg::link_state_e state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] rx_q, rx_d;
    logic [15:0] tx_q, tx_d;
    logic [7:0] cmd_q, cmd_d;
    logic miso_q, miso_d;
    logic addr_done;
    logic commit;
    logic [15:0] rd_data;
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        cmd_d = cmd_q;
        miso_d = miso_q;
        addr_done = 1'b0;
        commit = 1'b0;
        unique case (state_q)
            turn_tally_pkg::LINK_IDLE: begin
                cnt_d = 5'h00;
                if (cs_act) begin
                    state_d = turn_tally_pkg::LINK_CMD;
                end
            end
            turn_tally_pkg::LINK_CMD: begin
                if (sclk_rise) begin
                    rx_d = {rx_q[14:0], mosi_s};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == turn_tally_pkg::CMD_LAST) begin
                        cmd_d = {rx_q[6:0], mosi_s};
                        addr_done = 1'b1;
                        tx_d = rd_data;
                        state_d = turn_tally_pkg::LINK_DATA;
                    end
                end
            end
            turn_tally_pkg::LINK_DATA: begin
                if (sclk_rise && cnt_q <= turn_tally_pkg::FRAME_LAST) begin
                    rx_d = {rx_q[14:0], mosi_s};
                    cnt_d = cnt_q + 5'h01;
                    commit = (cnt_q == turn_tally_pkg::FRAME_LAST) & cmd_q[turn_tally_pkg::WRITE_FLAG_BIT];
                end
                if (sclk_fall) begin
                    miso_d = tx_q[15];
                    tx_d = {tx_q[14:0], 1'b0};
                end
            end
        endcase
        // a frame ends whenever select lifts; a short frame commits nothing
        if (!cs_act) begin
            state_d = turn_tally_pkg::LINK_IDLE;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= turn_tally_pkg::LINK_IDLE;
            cnt_q <= 5'h00;
            rx_q <= turn_tally_pkg::WORD_RESET_VAL;
            tx_q <= turn_tally_pkg::WORD_RESET_VAL;
            cmd_q <= 8'h00;
            miso_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            cmd_q <= cmd_d;
            miso_q <= miso_d;
        end
    end
    assign MISO = miso_q;
    assign MISO_OE_N = ~cs_act;

    // register decode; the read address is in the command byte being completed
    logic [6:0] acc_addr;
    logic is_write;
    logic [15:0] wr_data;
    assign acc_addr = addr_done ? cmd_d[6:0] : cmd_q[6:0];
    assign is_write = cmd_d[turn_tally_pkg::WRITE_FLAG_BIT];
    assign wr_data = rx_d;
    logic rd_angle, rd_pri_live, rd_pri_snap, rd_sec, rd_sec_snap;
    assign rd_angle = addr_done & ~is_write & (acc_addr == turn_tally_pkg::ANGLE_MAIN_ADDR);
    assign rd_pri_live = addr_done & ~is_write & (acc_addr == turn_tally_pkg::PRIMARY_LIVE_ADDR);
    assign rd_pri_snap = addr_done & ~is_write & (acc_addr == turn_tally_pkg::PRIMARY_SNAP_ADDR);
    assign rd_sec = addr_done & ~is_write & (acc_addr == turn_tally_pkg::SECONDARY_TALLY_ADDR);
    assign rd_sec_snap = addr_done & ~is_write & (acc_addr == turn_tally_pkg::SECONDARY_SNAP_ADDR);

    // tally and flag state
    logic [10:0] pri_cnt_q, pri_cnt_d, sec_cnt_q, sec_cnt_d;
    logic pri_ovf_q, pri_ovf_d, sec_ovf_q, sec_ovf_d;
    logic pri_warn_q, pri_warn_d, sec_warn_q, sec_warn_d;
    logic pri_sleep_q, pri_sleep_d, sec_sleep_q, sec_sleep_d;
    logic stuck_q, stuck_d, check_q, check_d, lp_q, init_q;
    logic [15:0] pri_snap_q, pri_snap_d, sec_snap_q, sec_snap_d;
    logic [15:0] echo_q, echo_d;
    logic cust_q, cust_d, fact_q, fact_d;
    logic sec_up, sec_dn, lp_exit, pri_any, sec_any;
    logic [15:0] sec_word;
    assign lp_exit = lp_q & ~LOW_POWER;
    assign pri_any = pri_ovf_q | pri_warn_q;
    assign sec_any = sec_ovf_q | sec_warn_q;
    assign sec_word = {pri_any, sec_sleep_q, sec_warn_q, sec_ovf_q, 1'b0, sec_cnt_q};
    always_comb begin
        sec_up = 1'b0;
        sec_dn = 1'b0;
        // select value three names no path, so the tally holds
        if (REDUNDANT_PATH_SELECT != 2'h3) begin
            sec_up = RED_STEP_UP[REDUNDANT_PATH_SELECT];
            sec_dn = RED_STEP_DN[REDUNDANT_PATH_SELECT];
        end
    end
    always_comb begin
        unique case (acc_addr)
            turn_tally_pkg::ANGLE_MAIN_ADDR: rd_data = ANGLE_MAIN;
            turn_tally_pkg::PRIMARY_SNAP_ADDR: rd_data = pri_snap_q;
            turn_tally_pkg::SECONDARY_TALLY_ADDR: rd_data = sec_word;
            turn_tally_pkg::SECONDARY_SNAP_ADDR: rd_data = sec_snap_q;
            turn_tally_pkg::UNLOCK_ADDR: rd_data = {14'h0000, cust_q, fact_q};
            turn_tally_pkg::ECHO_ADDR: rd_data = echo_q;
            default: rd_data = turn_tally_pkg::WORD_RESET_VAL;
        endcase
    end
    always_comb begin
        pri_cnt_d = pri_cnt_q;
        sec_cnt_d = sec_cnt_q;
        pri_ovf_d = pri_ovf_q;
        sec_ovf_d = sec_ovf_q;
        // counts wrap; the overflow flag records that the range was left
        if (PRI_STEP_UP != PRI_STEP_DN) begin
            pri_cnt_d = PRI_STEP_UP ? pri_cnt_q + 11'h001 : pri_cnt_q - 11'h001;
            if ((PRI_STEP_UP && pri_cnt_q == turn_tally_pkg::TALLY_MAX)
                    || (PRI_STEP_DN && pri_cnt_q == turn_tally_pkg::TALLY_MIN)) begin
                pri_ovf_d = 1'b1;
            end
        end
        if (sec_up != sec_dn) begin
            sec_cnt_d = sec_up ? sec_cnt_q + 11'h001 : sec_cnt_q - 11'h001;
            if ((sec_up && sec_cnt_q == turn_tally_pkg::TALLY_MAX)
                    || (sec_dn && sec_cnt_q == turn_tally_pkg::TALLY_MIN)) begin
                sec_ovf_d = 1'b1;
            end
        end
        if (TALLY_RESET_CMD) begin
            pri_cnt_d = turn_tally_pkg::TALLY_RESET_VAL;
            sec_cnt_d = turn_tally_pkg::TALLY_RESET_VAL;
            pri_ovf_d = 1'b0;
            sec_ovf_d = 1'b0;
        end
        check_d = ~init_q | lp_exit;
        stuck_d = stuck_q | (check_q & STUCK_ZERO_SEEN);
        pri_warn_d = PRI_WARN_COND | stuck_q;
        sec_warn_d = SUPPLY_FAULT_A | FIELD_FAULT_B | SUPPLY_UNDERVOLT_FAULT | (LOW_POWER & LP_ACCURACY_THREAT)
            | OVERSPEED | stuck_q;
        // read-clear first so a same-cycle return still sets the flag
        pri_sleep_d = pri_sleep_q & ~rd_pri_live;
        sec_sleep_d = sec_sleep_q & ~rd_sec;
        if (lp_exit && !TRANSPORT_EN) begin
            pri_sleep_d = 1'b1;
            sec_sleep_d = 1'b1;
        end
        pri_snap_d = pri_snap_q;
        sec_snap_d = sec_snap_q;
        if (rd_pri_snap) begin
            pri_snap_d[turn_tally_pkg::SLEEP_RET_BIT] = 1'b0;
        end
        if (rd_sec_snap) begin
            sec_snap_d[turn_tally_pkg::SLEEP_RET_BIT] = 1'b0;
        end
        if (rd_angle) begin
            pri_snap_d = {sec_any, pri_sleep_q, pri_warn_q, pri_ovf_q, 1'b0, pri_cnt_q};
            sec_snap_d = {pri_any, sec_sleep_q, sec_warn_q, sec_ovf_q, 1'b0, sec_cnt_q};
        end
        echo_d = echo_q;
        cust_d = cust_q;
        fact_d = fact_q;
        if (commit && cmd_q[6:0] == turn_tally_pkg::ECHO_ADDR) begin
            echo_d = wr_data;
        end
        // an unlock write is a key, never stored; a wrong key relocks both
        if (commit && cmd_q[6:0] == turn_tally_pkg::UNLOCK_ADDR) begin
            cust_d = (wr_data == CUSTOMER_KEY);
            fact_d = (wr_data == FACTORY_KEY);
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pri_cnt_q <= turn_tally_pkg::TALLY_RESET_VAL;
            sec_cnt_q <= turn_tally_pkg::TALLY_RESET_VAL;
            pri_ovf_q <= 1'b0;
            sec_ovf_q <= 1'b0;
            pri_warn_q <= 1'b0;
            sec_warn_q <= 1'b0;
            pri_sleep_q <= 1'b0;
            sec_sleep_q <= 1'b0;
            stuck_q <= 1'b0;
            check_q <= 1'b0;
            lp_q <= 1'b0;
            init_q <= 1'b0;
            pri_snap_q <= turn_tally_pkg::WORD_RESET_VAL;
            sec_snap_q <= turn_tally_pkg::WORD_RESET_VAL;
            echo_q <= turn_tally_pkg::WORD_RESET_VAL;
            cust_q <= 1'b0;
            fact_q <= 1'b0;
        end else begin
            pri_cnt_q <= pri_cnt_d;
            sec_cnt_q <= sec_cnt_d;
            pri_ovf_q <= pri_ovf_d;
            sec_ovf_q <= sec_ovf_d;
            pri_warn_q <= pri_warn_d;
            sec_warn_q <= sec_warn_d;
            pri_sleep_q <= pri_sleep_d;
            sec_sleep_q <= sec_sleep_d;
            stuck_q <= stuck_d;
            check_q <= check_d;
            lp_q <= LOW_POWER;
            init_q <= 1'b1;
            pri_snap_q <= pri_snap_d;
            sec_snap_q <= sec_snap_d;
            echo_q <= echo_d;
            cust_q <= cust_d;
            fact_q <= fact_d;
        end
    end
    assign STUCK_CHECK = check_q;
    assign CUSTOMER_UNLOCKED = cust_q;
    assign FACTORY_UNLOCKED = fact_q;

    sequence s_angle_read;
        rd_angle ##1 1'b1;
    endsequence
    property p_snapshot;
        @(posedge CLK) disable iff (!RESET_N)
        rd_angle |=> sec_snap_q[10:0] == $past(sec_cnt_q) && pri_snap_q[10:0] == $past(pri_cnt_q);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot missed tally");
    property p_any_fault;
        @(posedge CLK) disable iff (!RESET_N)
        s_angle_read |-> sec_snap_q[turn_tally_pkg::ANY_FAULT_BIT] == $past(pri_ovf_q | pri_warn_q);
    endproperty
    a_any_fault: assert property (p_any_fault) else $error("any-fault bit wrong");
    property p_sleep_ret;
        @(posedge CLK) disable iff (!RESET_N)
        lp_q && !LOW_POWER && !TRANSPORT_EN |=> sec_sleep_q ##1 (sec_sleep_q || $past(rd_sec));
    endproperty
    a_sleep_ret: assert property (p_sleep_ret) else $error("sleep return flag lost");
    property p_warn;
        @(posedge CLK) disable iff (!RESET_N)
        SUPPLY_FAULT_A || FIELD_FAULT_B || SUPPLY_UNDERVOLT_FAULT || OVERSPEED |=> sec_warn_q;
    endproperty
    a_warn: assert property (p_warn) else $error("secondary warning not raised");
    property p_stuck;
        @(posedge CLK) disable iff (!RESET_N)
        check_q && STUCK_ZERO_SEEN |=> stuck_q [*3] ##0 sec_warn_q;
    endproperty
    a_stuck: assert property (p_stuck) else $error("stuck fault not held");
    property p_ovf_hold;
        @(posedge CLK) disable iff (!RESET_N)
        sec_ovf_q && !TALLY_RESET_CMD |=> sec_ovf_q;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped");
    property p_ovf_set;
        @(posedge CLK) disable iff (!RESET_N)
        PRI_STEP_UP && !PRI_STEP_DN && !TALLY_RESET_CMD && pri_cnt_q == turn_tally_pkg::TALLY_MAX
        |=> pri_ovf_q && pri_cnt_q == turn_tally_pkg::TALLY_MIN;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("primary overflow missed");
    property p_unlock;
        @(posedge CLK) disable iff (!RESET_N)
        commit && cmd_q[6:0] == turn_tally_pkg::UNLOCK_ADDR
        |=> cust_q == ($past(wr_data) == CUSTOMER_KEY) && fact_q == ($past(wr_data) == FACTORY_KEY);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock state wrong");
    property p_echo;
        @(posedge CLK) disable iff (!RESET_N)
        commit && cmd_q[6:0] == turn_tally_pkg::ECHO_ADDR |=> echo_q == $past(wr_data);
    endproperty
    a_echo: assert property (p_echo) else $error("echo word not stored");
    property p_bit11;
        @(posedge CLK) disable iff (!RESET_N)
        // angle and echo words use bit 11 as data, so only tally reads are held to it
        rd_pri_snap || rd_sec || rd_sec_snap |-> !rd_data[11];
    endproperty
    a_bit11: assert property (p_bit11) else $error("bit 11 not zero");
endmodule
`default_nettype wire

// [tb/link_ctrl_model.sv]
// serial link controller model that sends whole 24-bit frames
`timescale 1ns/1ns
`default_nettype none
module link_ctrl_model (
    // pacing clock
    input wire logic clk,
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // mode 0, msb first, 8 clk per link period; link clock stands still between frames
    task automatic xfer(input logic [23:0] frame, output logic [15:0] rdata);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            mosi = frame[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            if (i < 16) begin
                rdata[i] = miso;
            end
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        // released data line must not keep showing the last bit
        mosi = ~mosi;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [tb/turn_tally_regs_tb.sv]
// self-checking bench for the turn tally register group
`timescale 1ns/1ns
`default_nettype none
module turn_tally_regs_tb;
    localparam logic [15:0] CUST_KEY = 16'h3c11; // arbitrary value
    localparam logic [15:0] FACT_KEY = 16'hc322; // arbitrary value
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe_n, miso_w, stuck_check, cust_unl, fact_unl;
    logic miso_last = 1'b0;
    logic pri_up = 1'b0, pri_dn = 1'b0, low_power = 1'b0, transport_en = 1'b0;
    logic lp_threat = 1'b0, pri_warn = 1'b0, stuck_seen = 1'b0, tally_rst = 1'b0;
    logic [2:0] red_up = 3'h0, red_dn = 3'h0;
    logic [1:0] path_sel = 2'h1;
    logic [3:0] faults = 4'h0;
    int err_count = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    // an undriven data line shows the inverse of its last value
    always @(posedge clk) if (!miso_oe_n) miso_last <= miso;
    assign miso_w = miso_oe_n ? ~miso_last : miso;
    link_ctrl_model u_ctrl (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
    turn_tally_regs #(.CUSTOMER_KEY(CUST_KEY), .FACTORY_KEY(FACT_KEY)) u_dut (
        .CLK(clk), .RESET_N(reset_n), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso),
        .MISO_OE_N(miso_oe_n), .ANGLE_MAIN(16'hbeef), .PRI_STEP_UP(pri_up), .PRI_STEP_DN(pri_dn),
        .RED_STEP_UP(red_up), .RED_STEP_DN(red_dn), .REDUNDANT_PATH_SELECT(path_sel),
        .LOW_POWER(low_power), .TRANSPORT_EN(transport_en), .SUPPLY_FAULT_A(faults[0]),
        .FIELD_FAULT_B(faults[1]), .SUPPLY_UNDERVOLT_FAULT(faults[2]), .LP_ACCURACY_THREAT(lp_threat),
        .OVERSPEED(faults[3]), .PRI_WARN_COND(pri_warn), .STUCK_ZERO_SEEN(stuck_seen),
        .TALLY_RESET_CMD(tally_rst), .STUCK_CHECK(stuck_check), .CUSTOMER_UNLOCKED(cust_unl),
        .FACTORY_UNLOCKED(fact_unl));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        u_ctrl.xfer({1'b0, addr, 16'h0000}, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        logic [15:0] d;
        u_ctrl.xfer({1'b1, addr, data}, d);
    endtask
    task automatic steps(input int n, input logic pu, input logic pd, input logic [2:0] ru, input logic [2:0] rn);
        repeat (n) begin
            @(negedge clk);
            {pri_up, pri_dn, red_up, red_dn} = {pu, pd, ru, rn};
            @(negedge clk);
            {pri_up, pri_dn, red_up, red_dn} = 8'h00;
        end
    endtask
    task automatic pulse_tally_rst;
        @(negedge clk);
        tally_rst = 1'b1;
        @(negedge clk);
        tally_rst = 1'b0;
    endtask
    task automatic do_reset;
        @(negedge clk);
        reset_n = 1'b0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask
    task automatic t_reset_and_map;
        chk({15'h0000, miso_oe_n}, 16'h0001);
        rd(7'h1a, 16'h0000);
        rd(7'h1b, 16'h0000);
        rd(7'h1e, 16'h0000);
        rd(7'h1f, 16'h0000);
        rd(7'h05, 16'h0000);
    endtask
    task automatic t_echo;
        wr(7'h1f, 16'ha5c3);
        rd(7'h1f, 16'ha5c3);
        wr(7'h1f, 16'h5a3c);
        rd(7'h1f, 16'h5a3c);
        wr(7'h1a, 16'hffff);
        rd(7'h1a, 16'h0000);
    endtask
    task automatic t_unlock;
        wr(7'h1e, CUST_KEY);
        rd(7'h1e, 16'h0002);
        chk({15'h0000, cust_unl}, 16'h0001);
        wr(7'h1e, 16'h0000);
        rd(7'h1e, 16'h0000);
        wr(7'h1e, FACT_KEY);
        rd(7'h1e, 16'h0001);
        chk({15'h0000, fact_unl}, 16'h0001);
        wr(7'h1e, 16'h0000);
        rd(7'h1e, 16'h0000);
    endtask
    task automatic t_tally;
        steps(3, 1'b0, 1'b0, 3'h2, 3'h1);
        steps(5, 1'b0, 1'b0, 3'h0, 3'h2);
        steps(2, 1'b1, 1'b0, 3'h0, 3'h0);
        steps(1, 1'b1, 1'b1, 3'h0, 3'h0);
        rd(7'h1a, 16'h07fe);
        rd(7'h0e, 16'hbeef);
        rd(7'h19, 16'h0002);
        rd(7'h1b, 16'h07fe);
        steps(1, 1'b1, 1'b0, 3'h2, 3'h0);
        rd(7'h19, 16'h0002);
        rd(7'h1b, 16'h07fe);
        rd(7'h0e, 16'hbeef);
        rd(7'h19, 16'h0003);
        rd(7'h1b, 16'h07ff);
        path_sel = 2'h3;
        steps(1, 1'b0, 1'b0, 3'h7, 3'h0);
        rd(7'h1a, 16'h07ff);
        path_sel = 2'h0;
        steps(1, 1'b0, 1'b0, 3'h1, 3'h0);
        rd(7'h1a, 16'h0000);
    endtask
    task automatic t_flags;
        for (int i = 0; i < 4; i++) begin
            faults = 4'h1 << i;
            rd(7'h1a, 16'h2000);
            faults = 4'h0;
            rd(7'h1a, 16'h0000);
        end
        low_power = 1'b1;
        lp_threat = 1'b1;
        rd(7'h1a, 16'h2000);
        low_power = 1'b0;
        rd(7'h1a, 16'h4000);
        rd(7'h1a, 16'h0000);
        lp_threat = 1'b0;
        transport_en = 1'b1;
        low_power = 1'b1;
        repeat (10) @(negedge clk);
        low_power = 1'b0;
        rd(7'h1a, 16'h0000);
        pri_warn = 1'b1;
        rd(7'h1a, 16'h8000);
        rd(7'h0e, 16'hbeef);
        rd(7'h1b, 16'h8000);
        rd(7'h19, 16'h6003);
        rd(7'h19, 16'h2003);
        pri_warn = 1'b0;
        rd(7'h13, 16'h0000);
    endtask
    task automatic t_overflow;
        pulse_tally_rst();
        path_sel = 2'h2;
        steps(1023, 1'b1, 1'b0, 3'h4, 3'h0);
        rd(7'h1a, 16'h03ff);
        steps(1, 1'b1, 1'b0, 3'h4, 3'h0);
        rd(7'h1a, 16'h9400);
        rd(7'h0e, 16'hbeef);
        rd(7'h19, 16'h9400);
        rd(7'h1b, 16'h9400);
        pulse_tally_rst();
        rd(7'h1a, 16'h0000);
    endtask
    // the stuck fault feeds both warnings, so bit 15 rises with bit 13
    task automatic t_stuck;
        stuck_seen = 1'b1;
        low_power = 1'b1;
        repeat (10) @(negedge clk);
        low_power = 1'b0;
        @(negedge clk);
        chk({15'h0000, stuck_check}, 16'h0001);
        @(negedge clk);
        chk({15'h0000, stuck_check}, 16'h0000);
        repeat (8) @(negedge clk);
        stuck_seen = 1'b0;
        pulse_tally_rst();
        rd(7'h1a, 16'ha000);
        stuck_seen = 1'b1;
        do_reset();
        stuck_seen = 1'b0;
        rd(7'h1a, 16'ha000);
        do_reset();
        rd(7'h1a, 16'h0000);
        rd(7'h1f, 16'h0000);
    endtask
    task automatic test_done;
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_reset_and_map();
        t_echo();
        t_unlock();
        t_tally();
        t_flags();
        t_overflow();
        t_stuck();
        test_done();
    end
    // about 14k cycles expected; the limit leaves wide margin
    initial begin
        #600000;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
